// ---- common/sdms_map.vh ----
`ifndef SDMS_MAP_VH
`define SDMS_MAP_VH

// Register byte offsets, one aligned word each
`define SDMS_ADDR_W 8
`define SDMS_ADDR_CTRL 8'h00
`define SDMS_ADDR_STATUS 8'h04
`define SDMS_ADDR_POSITION 8'h08
`define SDMS_ADDR_COILS 8'h0c
`define SDMS_ADDR_INTERVAL 8'h10

// Control: microstep resolution select, 0 = 256 microsteps .. 8 = fullstep
`define SDMS_CTRL_MRES_LSB 0
`define SDMS_CTRL_MRES_MSB 3
`define SDMS_CTRL_MRES_RESET 4'h0
`define SDMS_MRES_FULL 4'h8

// Status bit positions
`define SDMS_STAT_STST 0
`define SDMS_STAT_INDEX 1
`define SDMS_STAT_STANDBY 2
`define SDMS_STAT_DIR 3
`define SDMS_STAT_BUSY 4

// Field positions in position and coil registers
`define SDMS_POS_COUNT_LSB 0
`define SDMS_POS_TARGET_LSB 16
`define SDMS_COIL_A_LSB 0
`define SDMS_COIL_B_LSB 16

// Sequencer geometry and timing
`define SDMS_POS_W 10
`define SDMS_AMP_W 9
`define SDMS_INDEX_POS 10'h000
`define SDMS_COS_SHIFT 10'h100
`define SDMS_INTERVAL_W 20

// AHB-Lite encodings
`define SDMS_HSIZE_WORD 3'b010
`define SDMS_HRESP_OKAY 1'b0

`endif

// ---- testbench/sdms_sequencer_checker.sv ----
`timescale 1ns/10ps
`include "sdms_map.vh"
module sdms_sequencer_checker #(
    parameter INTERVAL_W = 20
) (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire step_in,
    input wire dir_in,
    input wire power_down_select,
    input wire index_out,
    input wire standstill,
    input wire standby_reduce,
    input wire [`SDMS_POS_W-1:0] microstep_position_count,
    input wire [`SDMS_AMP_W-1:0] coil_a,
    input wire [`SDMS_AMP_W-1:0] coil_b
);
    localparam int LIM = (1 << INTERVAL_W) - 1;
    logic [INTERVAL_W:0] quiet_q;
    logic step_q;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Clocks since the last step rise; starts saturated, as the interval counter does
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_q <= '1;
            step_q <= 1'b0;
        end else begin
            step_q <= step_in;
            if (step_in && !step_q) begin
                quiet_q <= '0;
            end else if (quiet_q != '1) begin
                quiet_q <= quiet_q + 1'b1;
            end
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_index: assert property ($past(hresetn) |-> index_out == ($past(microstep_position_count) == 10'h000))
        else $error("index does not follow position zero");
    a_coil_zero: assert property ($past(hresetn) && $past(microstep_position_count) == 10'h000
        |-> coil_a == 9'h0ff && coil_b == 9'h000) else $error("coil values wrong at zero");
    a_coil_full: assert property ($past(hresetn) && $past(microstep_position_count) == 10'h080
        |-> coil_a == coil_b) else $error("coils unequal at fullstep point");
    a_standby: assert property ($stable(standstill) && $stable(power_down_select)
        |-> standby_reduce == (standstill && power_down_select)) else $error("standby mismatch");
    a_jump: assert property (standstill && $rose(step_in)
        |-> ##2 $stable(microstep_position_count) ##1 !$stable(microstep_position_count))
        else $error("step not taken after synchroniser");
    a_stst_clear: assert property (standstill && $rose(step_in) |-> ##3 !standstill)
        else $error("standstill not cleared by step");
    a_dir: assert property (standstill && $rose(step_in) |-> ##3
        ((microstep_position_count - $past(microstep_position_count, 3)) >= 10'h200) == $past(dir_in, 3))
        else $error("position moved the wrong way");
    a_stst_set: assert property (quiet_q == LIM + 12 |-> standstill) else $error("standstill missing");
    a_stst_quiet: assert property (quiet_q >= 4 && quiet_q <= LIM - 4 |-> !standstill)
        else $error("standstill too early");
endmodule
bind sdms_sequencer sdms_sequencer_checker #(.INTERVAL_W(INTERVAL_W)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .step_in(step_in), .dir_in(dir_in), .power_down_select(power_down_select),
    .index_out(index_out), .standstill(standstill), .standby_reduce(standby_reduce),
    .microstep_position_count(microstep_position_count), .coil_a(coil_a), .coil_b(coil_b));

// ---- testbench/sdms_step_source.sv ----
`timescale 1ns/10ps
module sdms_step_source (
    input wire logic hclk,
    output logic step_in,
    output logic dir_in
);
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
    end
    // Direction settles two clocks ahead; period never under three clocks
    task automatic steps(input int n, input int per, input logic dir);
        @(posedge hclk);
        dir_in <= dir;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            step_in <= 1'b1;
            repeat (2) @(posedge hclk);
            step_in <= 1'b0;
            repeat (per - 2) @(posedge hclk);
        end
    endtask
endmodule

// ---- testbench/test_sdms_sequencer.sv ----
`timescale 1ns/10ps
`include "sdms_map.vh"
module test_sdms_sequencer;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic power_down_select = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdat;
    wire hready, hresp, step_in, dir_in, index_out, standstill, standby_reduce;
    wire [31:0] hrdata;
    wire [9:0] pos;
    wire [8:0] coil_a, coil_b;
    int err_total = 0, tests_run = 0, cyc = 0, e = 0, p;
    sdms_sequencer #(.INTERVAL_W(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .step_in(step_in), .dir_in(dir_in),
        .power_down_select(power_down_select), .index_out(index_out), .standstill(standstill),
        .standby_reduce(standby_reduce), .microstep_position_count(pos), .coil_a(coil_a), .coil_b(coil_b));
    sdms_step_source src (.hclk(hclk), .step_in(step_in), .dir_in(dir_in));
    initial begin
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
            err_total++;
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
        xfer(1'b0, a, 32'h0, 3'b010);
        chk(rdat & m, x, s);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rchk(`SDMS_ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
        rchk(`SDMS_ADDR_POSITION, 32'hffffffff, 32'h0, "position reset");
        rchk(`SDMS_ADDR_STATUS, 32'h1f, 32'h3, "status reset");
        rchk(`SDMS_ADDR_COILS, 32'h01ff01ff, 32'hff, "coils at zero");
        xfer(1'b1, 8'h14, 32'h5, 3'b010);
        xfer(1'b1, `SDMS_ADDR_CTRL, 32'h8, 3'b000);
        rchk(8'h14, 32'hffffffff, 32'h0, "unmapped read");
        rchk(`SDMS_ADDR_CTRL, 32'hffffffff, 32'h0, "byte write ignored");
        $display("test reset and bus done");
        src.steps(3, 4, 1'b0);
        repeat (4) @(posedge hclk);
        chk(32'(pos), 32'h3, "up three");
        src.steps(4, 3, 1'b1);
        repeat (4) @(posedge hclk);
        chk(32'(pos), 32'h3ff, "down wrap");
        src.steps(1, 3, 1'b0);
        repeat (4) @(posedge hclk);
        chk(32'({pos, index_out}), 32'h1, "index at zero");
        $display("test finest stepping done");
        for (int r = 6; r <= 8; r++) begin
            p = 1 << r;
            e = (e & ~(p - 1)) | (p / 2);
            xfer(1'b1, `SDMS_ADDR_CTRL, r, 3'b010);
            repeat (4) @(posedge hclk);
            chk(32'(pos), e, "snap");
            src.steps(1, 300, 1'b0);
            e = (e + p) % 1024;
            chk(32'(pos), e, "coarse step");
            chk(32'(standstill), 32'h1, "slow step standstill");
        end
        src.steps(2, 300, 1'b1);
        chk(32'(pos), 32'd896, "fullstep down wrap");
        $display("test resolution change done");
        xfer(1'b1, `SDMS_ADDR_CTRL, 32'h4, 3'b010);
        src.steps(2, 120, 1'b0);
        chk(32'(pos), 32'd928, "jumps after standstill");
        src.steps(1, 4, 1'b0);
        rchk(`SDMS_ADDR_STATUS, 32'h11, 32'h10, "interpolating");
        chk(32'(pos), 32'd928, "caught up to old target");
        repeat (14) @(posedge hclk);
        chk(32'(pos > 10'd928 && pos < 10'd944), 32'h1, "spread microsteps");
        // Early step edge: leftover microsteps dropped, count lands on old target
        src.steps(1, 4, 1'b0);
        chk(32'(pos), 32'd944, "unissued microsteps skipped");
        repeat (200) @(posedge hclk);
        chk(32'(pos), 32'd960, "all microsteps issued");
        $display("test interpolation done");
        repeat (100) @(posedge hclk);
        power_down_select <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(32'(standby_reduce), 32'h1, "standby on");
        power_down_select <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(32'(standby_reduce), 32'h0, "standby off");
        $display("test standby done");
        finish_test();
    end
endmodule

// ---- verilog/sdms_sequencer.v ----
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "sdms_map.vh"

module sdms_sequencer #(
    parameter INTERVAL_W = `SDMS_INTERVAL_W
) (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    step_in,
    dir_in,
    power_down_select,
    index_out,
    standstill,
    standby_reduce,
    microstep_position_count,
    coil_a,
    coil_b
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output wire hreadyout;
    output wire hresp;
    input wire step_in;
    input wire dir_in;
    input wire power_down_select;
    output reg index_out;
    output wire standstill;
    output reg standby_reduce;
    output wire [`SDMS_POS_W-1:0] microstep_position_count;
    output reg [`SDMS_AMP_W-1:0] coil_a;
    output reg [`SDMS_AMP_W-1:0] coil_b;

    localparam [INTERVAL_W-1:0] INT_LIMIT = {INTERVAL_W{1'b1}};
    localparam [INTERVAL_W-1:0] INT_ONE = {{(INTERVAL_W-1){1'b0}}, 1'b1};

    // Values above fullstep fold onto fullstep
    function [3:0] eff_mres;
        input [3:0] sel;
        begin
            eff_mres = (sel > `SDMS_MRES_FULL) ? `SDMS_MRES_FULL : sel;
        end
    endfunction

    function [`SDMS_POS_W-1:0] step_width;
        input [3:0] m;
        begin
            step_width = 10'h001 << m;
        end
    endfunction

    // Valid grid is half a width off the cell start; nearest point is its cell centre
    function [`SDMS_POS_W-1:0] snap;
        input [`SDMS_POS_W-1:0] p;
        input [3:0] m;
        reg [`SDMS_POS_W-1:0] w;
        begin
            w = step_width(m);
            if (m == 4'h0) begin
                snap = p;
            end else begin
                snap = (p & ~(w - 10'h001)) | {1'b0, w[`SDMS_POS_W-1:1]};
            end
        end
    endfunction

    reg step_s1_q;
    reg step_s2_q;
    reg step_s3_q;
    reg dir_s1_q;
    reg dir_s2_q;
    reg [3:0] ctrl_mres_q;
    reg [3:0] mres_q;
    reg [`SDMS_POS_W-1:0] count_q;
    reg [`SDMS_POS_W-1:0] tgt_q;
    reg dir_q;
    reg [INTERVAL_W-1:0] int_cnt_q;
    reg [INTERVAL_W-1:0] last_int_q;
    reg [INTERVAL_W-1:0] tick_q;
    reg stst_q;
    reg wr_pend_q;
    reg [`SDMS_ADDR_W-1:0] addr_q;

    wire step_rise;
    wire [3:0] mres_new;
    wire coarser;
    wire [`SDMS_POS_W-1:0] base_tgt;
    wire [`SDMS_POS_W-1:0] width;
    wire [`SDMS_POS_W-1:0] step_tgt;
    wire prev_sat;
    wire jump;
    wire [INTERVAL_W-1:0] spacing_raw;
    wire [INTERVAL_W-1:0] spacing;
    wire tick_due;
    wire busy;
    wire [`SDMS_AMP_W-1:0] amp_a;
    wire [`SDMS_AMP_W-1:0] amp_b;
    wire accept;
    wire addr_ok;
    reg [31:0] rd_mux;

    // Two flops per input; the third step flop only feeds the edge detector
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_s1_q <= 1'b0;
            step_s2_q <= 1'b0;
            step_s3_q <= 1'b0;
            dir_s1_q <= 1'b0;
            dir_s2_q <= 1'b0;
        end else begin
            step_s1_q <= step_in;
            step_s2_q <= step_s1_q;
            step_s3_q <= step_s2_q;
            dir_s1_q <= dir_in;
            dir_s2_q <= dir_s1_q;
        end
    end

    // High and low each need only be held one clock to be seen
    assign step_rise = step_s2_q & ~step_s3_q;

    assign mres_new = eff_mres(ctrl_mres_q);
    assign coarser = mres_new > mres_q;
    assign base_tgt = coarser ? snap(tgt_q, mres_new) : tgt_q;
    assign width = step_width(mres_new);
    // Ten-bit arithmetic wraps 1023 <-> 0 on its own
    assign step_tgt = dir_s2_q ? (base_tgt - width) : (base_tgt + width);

    assign prev_sat = (last_int_q == INT_LIMIT);
    // No interval to divide at finest setting or after standstill
    assign jump = (mres_new == 4'h0) | stst_q | prev_sat;

    // Width is a power of two, so the divide is a shift
    assign spacing_raw = last_int_q >> mres_q;
    assign spacing = (spacing_raw == {INTERVAL_W{1'b0}}) ? INT_ONE : spacing_raw;
    assign tick_due = (tick_q + INT_ONE) >= spacing;
    assign busy = (count_q != tgt_q);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mres_q <= `SDMS_CTRL_MRES_RESET;
            count_q <= `SDMS_INDEX_POS;
            tgt_q <= `SDMS_INDEX_POS;
            dir_q <= 1'b0;
            tick_q <= {INTERVAL_W{1'b0}};
        end else begin
            mres_q <= mres_new;
            if (step_rise) begin
                tgt_q <= step_tgt;
                dir_q <= dir_s2_q;
                tick_q <= {INTERVAL_W{1'b0}};
                if (jump) begin
                    count_q <= step_tgt;
                end else begin
                    // Leftover microsteps of the old period are dropped here
                    count_q <= base_tgt;
                end
            end else if (coarser) begin
                tgt_q <= base_tgt;
                count_q <= base_tgt;
                tick_q <= {INTERVAL_W{1'b0}};
            end else if (busy && tick_due) begin
                count_q <= dir_q ? (count_q - 10'h001) : (count_q + 10'h001);
                tick_q <= {INTERVAL_W{1'b0}};
            end else if (tick_q != INT_LIMIT) begin
                tick_q <= tick_q + INT_ONE;
            end
        end
    end

    // Interval measure; saturation is the standstill condition
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_cnt_q <= INT_LIMIT;
            last_int_q <= INT_LIMIT;
            stst_q <= 1'b0;
        end else begin
            if (step_rise) begin
                last_int_q <= int_cnt_q;
                int_cnt_q <= INT_ONE;
                stst_q <= 1'b0;
            end else begin
                if (int_cnt_q != INT_LIMIT) begin
                    int_cnt_q <= int_cnt_q + INT_ONE;
                end
                if (int_cnt_q == INT_LIMIT) begin
                    stst_q <= 1'b1;
                end
            end
        end
    end

    sdms_sine_lut u_lut_a (
        .pos(count_q + `SDMS_COS_SHIFT),
        .amp(amp_a)
    );

    sdms_sine_lut u_lut_b (
        .pos(count_q),
        .amp(amp_b)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coil_a <= {`SDMS_AMP_W{1'b0}};
            coil_b <= {`SDMS_AMP_W{1'b0}};
            index_out <= 1'b0;
            standby_reduce <= 1'b0;
        end else begin
            coil_a <= amp_a;
            coil_b <= amp_b;
            index_out <= (count_q == `SDMS_INDEX_POS);
            standby_reduce <= stst_q & power_down_select;
        end
    end

    assign standstill = stst_q;
    assign microstep_position_count = count_q;

    // Zero-wait slave: address phase taken on hready, write lands in the data phase
    assign hreadyout = 1'b1;
    assign hresp = `SDMS_HRESP_OKAY;
    assign accept = hsel & hready & htrans[1];
    assign addr_ok = (haddr[31:`SDMS_ADDR_W] == {(32-`SDMS_ADDR_W){1'b0}}) & (haddr[1:0] == 2'b00);

    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr[`SDMS_ADDR_W-1:0])
            `SDMS_ADDR_CTRL: begin
                rd_mux[`SDMS_CTRL_MRES_MSB:`SDMS_CTRL_MRES_LSB] = ctrl_mres_q;
            end
            `SDMS_ADDR_STATUS: begin
                rd_mux[`SDMS_STAT_STST] = stst_q;
                rd_mux[`SDMS_STAT_INDEX] = index_out;
                rd_mux[`SDMS_STAT_STANDBY] = standby_reduce;
                rd_mux[`SDMS_STAT_DIR] = dir_s2_q;
                rd_mux[`SDMS_STAT_BUSY] = busy;
            end
            `SDMS_ADDR_POSITION: begin
                rd_mux[`SDMS_POS_COUNT_LSB+`SDMS_POS_W-1:`SDMS_POS_COUNT_LSB] = count_q;
                rd_mux[`SDMS_POS_TARGET_LSB+`SDMS_POS_W-1:`SDMS_POS_TARGET_LSB] = tgt_q;
            end
            `SDMS_ADDR_COILS: begin
                rd_mux[`SDMS_COIL_A_LSB+`SDMS_AMP_W-1:`SDMS_COIL_A_LSB] = coil_a;
                rd_mux[`SDMS_COIL_B_LSB+`SDMS_AMP_W-1:`SDMS_COIL_B_LSB] = coil_b;
            end
            `SDMS_ADDR_INTERVAL: begin
                rd_mux[INTERVAL_W-1:0] = last_int_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
        if (!addr_ok) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= {`SDMS_ADDR_W{1'b0}};
            hrdata <= 32'h0000_0000;
        end else begin
            if (hready) begin
                // Sub-word and misaligned writes are dropped
                wr_pend_q <= accept & hwrite & addr_ok & (hsize == `SDMS_HSIZE_WORD);
                addr_q <= haddr[`SDMS_ADDR_W-1:0];
            end
            if (accept && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_mres_q <= `SDMS_CTRL_MRES_RESET;
        end else if (wr_pend_q && (addr_q == `SDMS_ADDR_CTRL)) begin
            ctrl_mres_q <= hwdata[`SDMS_CTRL_MRES_MSB:`SDMS_CTRL_MRES_LSB];
        end
    end
endmodule

// ---- verilog/sdms_sine_lut.v ----
`timescale 1ns/10ps
`include "sdms_map.vh"

// Sine over 1024 positions; quarter wave of 33 points, linear fill between
module sdms_sine_lut (
    pos,
    amp
);
    input wire [`SDMS_POS_W-1:0] pos;
    output wire [`SDMS_AMP_W-1:0] amp;

    function [7:0] knot;
        input [5:0] k;
        begin
            case (k)
                6'h00: knot = 8'h00;
                6'h01: knot = 8'h0d;
                6'h02: knot = 8'h19;
                6'h03: knot = 8'h25;
                6'h04: knot = 8'h32;
                6'h05: knot = 8'h3e;
                6'h06: knot = 8'h4a;
                6'h07: knot = 8'h56;
                6'h08: knot = 8'h62;
                6'h09: knot = 8'h6d;
                6'h0a: knot = 8'h78;
                6'h0b: knot = 8'h83;
                6'h0c: knot = 8'h8e;
                6'h0d: knot = 8'h98;
                6'h0e: knot = 8'ha2;
                6'h0f: knot = 8'hab;
                6'h10: knot = 8'hb4;
                6'h11: knot = 8'hbd;
                6'h12: knot = 8'hc5;
                6'h13: knot = 8'hcd;
                6'h14: knot = 8'hd4;
                6'h15: knot = 8'hdb;
                6'h16: knot = 8'he1;
                6'h17: knot = 8'he7;
                6'h18: knot = 8'hec;
                6'h19: knot = 8'hf0;
                6'h1a: knot = 8'hf4;
                6'h1b: knot = 8'hf7;
                6'h1c: knot = 8'hfa;
                6'h1d: knot = 8'hfc;
                6'h1e: knot = 8'hfe;
                default: knot = 8'hff;
            endcase
        end
    endfunction

    wire [8:0] qx;
    wire [5:0] k;
    wire [2:0] f;
    wire [7:0] lo;
    wire [7:0] hi;
    wire [10:0] prod;
    wire [7:0] mag;

    // Second and fourth quadrants read the quarter wave mirrored
    assign qx = pos[8] ? (9'h100 - {1'b0, pos[7:0]}) : {1'b0, pos[7:0]};
    assign k = qx[8:3];
    assign f = qx[2:0];
    assign lo = knot(k);
    assign hi = knot(k + 6'h01);
    assign prod = (hi - lo) * f;
    assign mag = lo + prod[10:3];
    assign amp = pos[9] ? (9'h000 - {1'b0, mag}) : {1'b0, mag};
endmodule
